//--- rtl/tw_defs.svh
/*
 Constants for the two-wire serial block: register addresses, control bit positions, reset values.
 Assumes inclusion by bare name from tw_core and the testbench.
*/
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH
`define TW_ADDR_DATA      8'h9A
`define TW_ADDR_OWN       8'h9B
`define TW_ADDR_CTRL      8'hE8
`define TW_RST_DATA       8'h00
`define TW_RST_OWN        8'h55
`define TW_RST_CTRL       8'h00
`define TW_BIT_MDO        7
`define TW_BIT_MDE        6
`define TW_BIT_MCO        5
`define TW_BIT_MDI        4
`define TW_BIT_MODE       3
`define TW_BIT_IRST       2
`define TW_BIT_DIR        1
`define TW_BIT_FLAG       0
`define TW_BYTE_LAST      3'h7
`define TW_FIFO_DEPTH     4
`endif

//--- rtl/tw_pkg.sv
/*
 Types shared by the two-wire block and its testbench.
 Assumes tw_defs.svh is on the include path.
*/
package tw_pkg;
	typedef struct packed {
		logic [7:0] addr;   // Register address
		logic       wr;     // Write strobe
		logic       rd;     // Read strobe
		logic [7:0] wdata;  // Write data
	} tw_reg_req_type;

	typedef enum logic [2:0] {
		TW_IDLE  = 3'b000,
		TW_ADDR  = 3'b001,
		TW_AACK  = 3'b010,
		TW_RX    = 3'b011,
		TW_RACK  = 3'b100,
		TW_TX    = 3'b101,
		TW_TACK  = 3'b110,
		TW_WAIT  = 3'b111
	} tw_state_type;
endpackage : tw_pkg

//--- rtl/tw_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module tw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,   // Core clock
	input  wire logic             arst_n,    // Async reset
	input  wire logic             clr,       // Sync flush
	input  wire logic             in_valid,  // Write request
	output logic                  in_ready,  // Not full
	input  wire logic [WIDTH-1:0] in_data,   // Write data
	output logic                  out_valid, // Not empty
	input  wire logic             out_ready, // Read accept
	output logic      [WIDTH-1:0] out_data   // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest full and empty from the count
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage, no reset needed on data
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	// Pointers and count
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (clr) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + AW'(1);
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	property p_no_overflow;
		@(posedge sys_clk) disable iff (!arst_n) cnt_q <= (AW+1)'(DEPTH);
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule : tw_fifo

//--- rtl/tw_core.sv
/*
 Two-wire serial control block: software-driven master pins and a hardware byte slave.
 Assumes a core register port with one-cycle rd/wr strobes and external pins arriving asynchronously.
*/
`timescale 1ns/1ps
`include "tw_defs.svh"
module tw_core (
	input  wire logic                   sys_clk,          // Core clock 100 MHz
	input  wire logic                   arst_n,           // Async reset, active low
	input  wire tw_pkg::tw_reg_req_type reg_req,          // Register access
	output logic                  [7:0] reg_rdata,        // Read data, valid cycle after rd
	input  wire logic                   sync_serial_select, // High gives pins to sync serial
	input  wire logic                   sda_in,           // Data pin level
	output logic                        sda_out,          // Data pin drive value
	output logic                        sda_oe,           // Data pin drive enable
	input  wire logic                   scl_in,           // Clock pin level
	output logic                        scl_out,          // Clock pin drive value
	output logic                        scl_oe,           // Clock pin drive enable
	output logic                        byte_done_irq     // Pending slave interrupt
);
	import tw_pkg::*;

	function automatic logic hit(input tw_reg_req_type r, input logic [7:0] a);
		return r.addr == a;
	endfunction : hit

	////////////////////////////////////////////////////////////////
	logic [7:0]   ctrl_q;
	logic [7:0]   own_q;
	logic [7:0]   rx_q;
	logic [7:0]   sh_q;
	logic [2:0]   bit_q;
	tw_state_type st_q;
	logic         sda_s1_q, sda_s2_q, sda_s3_q;
	logic         scl_s1_q, scl_s2_q, scl_s3_q;
	logic         flag_set;
	logic         dat_acc;
	logic         slave_on;
	logic         scl_rise, scl_fall, start_c, stop_c;
	logic         drv_low_q;
	logic         txf_valid;
	logic [7:0]   txf_data;
	logic         txf_pop;

	assign dat_acc  = (reg_req.rd || reg_req.wr) && hit(reg_req, `TW_ADDR_DATA);
	assign slave_on = !ctrl_q[`TW_BIT_MODE] && !ctrl_q[`TW_BIT_IRST] && !sync_serial_select;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage one feeds stage two only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
		end else begin
			sda_s1_q <= sda_in;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
			scl_s1_q <= scl_in;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
		end
	end

	// Edge and bus-condition detection on synchronised levels
	assign scl_rise = scl_s2_q && !scl_s3_q;
	assign scl_fall = !scl_s2_q && scl_s3_q;
	assign start_c  = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
	assign stop_c   = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

	////////////////////////////////////////////////////////////////
	// Control register; hardware-owned bits protected from writes
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `TW_RST_CTRL;
		end else begin
			if (reg_req.wr && hit(reg_req, `TW_ADDR_CTRL)) begin
				ctrl_q[`TW_BIT_MDO]  <= reg_req.wdata[`TW_BIT_MDO];
				ctrl_q[`TW_BIT_MDE]  <= reg_req.wdata[`TW_BIT_MDE];
				ctrl_q[`TW_BIT_MCO]  <= reg_req.wdata[`TW_BIT_MCO];
				ctrl_q[`TW_BIT_MODE] <= reg_req.wdata[`TW_BIT_MODE];
				ctrl_q[`TW_BIT_IRST] <= reg_req.wdata[`TW_BIT_IRST];
			end
			// Master input latch on clock rise while undriven
			if (ctrl_q[`TW_BIT_MODE] && !ctrl_q[`TW_BIT_MDE] && scl_rise) begin
				ctrl_q[`TW_BIT_MDI] <= sda_s2_q;
			end
			// Direction follows slave phase
			if (!slave_on) begin
				ctrl_q[`TW_BIT_DIR] <= 1'b0;
			end else if (st_q == TW_TX || st_q == TW_TACK) begin
				ctrl_q[`TW_BIT_DIR] <= 1'b1;
			end else if (st_q == TW_RX || st_q == TW_ADDR) begin
				ctrl_q[`TW_BIT_DIR] <= 1'b0;
			end
			// Set wins over the clearing access in the same cycle
			if (flag_set) begin
				ctrl_q[`TW_BIT_FLAG] <= 1'b1;
			end else if (dat_acc || !slave_on) begin
				ctrl_q[`TW_BIT_FLAG] <= 1'b0;
			end
		end
	end

	// Own address register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			own_q <= `TW_RST_OWN;
		end else if (reg_req.wr && hit(reg_req, `TW_ADDR_OWN)) begin
			own_q <= reg_req.wdata;
		end
	end

	// Read mux, registered
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				`TW_ADDR_CTRL: reg_rdata <= ctrl_q;
				`TW_ADDR_OWN:  reg_rdata <= own_q;
				`TW_ADDR_DATA: reg_rdata <= rx_q;
				default:       reg_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit bytes queue up so software may load ahead of the master
	tw_fifo #(
		.WIDTH(8),
		.DEPTH(`TW_FIFO_DEPTH)
	) u_txf (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.clr      (!slave_on),
		.in_valid (reg_req.wr && hit(reg_req, `TW_ADDR_DATA)),
		.in_ready (), // A write into a full queue is dropped
		.in_data  (reg_req.wdata),
		.out_valid(txf_valid),
		.out_ready(txf_pop),
		.out_data (txf_data)
	);

	// Head is consumed when a transmit byte is loaded
	assign txf_pop = slave_on && scl_fall && (st_q == TW_AACK || st_q == TW_TACK)
		&& ((st_q == TW_AACK) ? sh_q[0] : !sda_s2_q) && drv_low_q == (st_q == TW_AACK);

	////////////////////////////////////////////////////////////////
	// Slave byte engine
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q  <= TW_IDLE;
			sh_q  <= 8'h00;
			bit_q <= 3'h0;
			rx_q  <= `TW_RST_DATA;
		end else if (!slave_on) begin
			st_q  <= TW_IDLE;
			bit_q <= 3'h0;
		end else if (stop_c) begin
			st_q <= TW_IDLE;
		end else if (start_c) begin
			st_q  <= TW_ADDR;
			bit_q <= 3'h0;
			sh_q  <= 8'h00; // Stale bits from the last frame would fake an address match
		end else begin
			case (st_q)
				TW_ADDR, TW_RX: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], sda_s2_q};
						bit_q <= bit_q + 3'h1;
					end
					if (scl_fall && bit_q == 3'h0 && st_q == TW_ADDR && sh_q[7:1] != 7'h00) begin
						st_q <= (sh_q[7:1] == own_q[6:0]) ? TW_AACK : TW_WAIT;
					end else if (scl_fall && bit_q == 3'h0 && st_q == TW_RX) begin
						rx_q <= sh_q;
						st_q <= TW_RACK;
					end
				end
				TW_AACK: begin
					if (scl_fall) begin
						st_q <= sh_q[0] ? TW_TX : TW_RX;
						sh_q <= txf_valid ? txf_data : 8'hFF;
					end
				end
				TW_RACK: begin
					if (scl_fall) begin
						st_q <= TW_RX;
					end
				end
				TW_TX: begin
					if (scl_fall) begin
						sh_q  <= {sh_q[6:0], 1'b1};
						bit_q <= bit_q + 3'h1;
						if (bit_q == `TW_BYTE_LAST) begin
							st_q <= TW_TACK;
						end
					end
				end
				TW_TACK: begin
					if (scl_rise) begin
						st_q <= sda_s2_q ? TW_WAIT : TW_TACK;
					end else if (scl_fall) begin
						st_q <= TW_TX;
						sh_q <= txf_valid ? txf_data : 8'hFF;
					end
				end
				TW_WAIT: st_q <= TW_WAIT;
				default: st_q <= TW_IDLE;
			endcase
		end
	end

	// Byte complete: nonzero received data byte or transmitted data byte finished
	assign flag_set = slave_on && scl_fall && !stop_c && !start_c &&
		((st_q == TW_RX && bit_q == 3'h0 && sh_q != 8'h00) || (st_q == TW_TX && bit_q == `TW_BYTE_LAST));

	// Slave pulls data low for ack or a zero transmit bit
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			drv_low_q <= 1'b0;
		end else if (!slave_on) begin
			drv_low_q <= 1'b0;
		end else if (scl_fall) begin
			case (st_q)
				TW_ADDR: drv_low_q <= (bit_q == 3'h0) && (sh_q[7:1] != 7'h00) && (sh_q[7:1] == own_q[6:0]);
				TW_RX:   drv_low_q <= (bit_q == 3'h0);
				TW_AACK: drv_low_q <= sh_q[0] && txf_valid && !txf_data[7];
				TW_TX:   drv_low_q <= (bit_q != `TW_BYTE_LAST) && !sh_q[6];
				TW_TACK: drv_low_q <= txf_valid && !txf_data[7];
				default: drv_low_q <= 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin drivers: master bits straight through, slave open-drain low
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_out <= 1'b1;
			sda_oe  <= 1'b0;
			scl_out <= 1'b1;
			scl_oe  <= 1'b0;
		end else if (sync_serial_select) begin
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
		end else if (ctrl_q[`TW_BIT_MODE]) begin
			sda_out <= ctrl_q[`TW_BIT_MDO];
			sda_oe  <= ctrl_q[`TW_BIT_MDE];
			scl_out <= ctrl_q[`TW_BIT_MCO];
			scl_oe  <= 1'b1;
		end else begin
			sda_out <= 1'b0;
			sda_oe  <= drv_low_q;
			scl_out <= 1'b1;
			scl_oe  <= 1'b0;
		end
	end

	// Interrupt request mirrors the flag one cycle later, dropped at once on a data register access
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			byte_done_irq <= 1'b0;
		end else begin
			byte_done_irq <= ctrl_q[`TW_BIT_FLAG] && !dat_acc;
		end
	end

	////////////////////////////////////////////////////////////////
	property p_mdo;
		@(posedge sys_clk) disable iff (!arst_n)
		(ctrl_q[`TW_BIT_MODE] && !sync_serial_select) |=> (sda_out == $past(ctrl_q[`TW_BIT_MDO]));
	endproperty
	a_mdo: assert property (p_mdo) else $error("data pin not following master bit");

	property p_mde;
		@(posedge sys_clk) disable iff (!arst_n)
		(ctrl_q[`TW_BIT_MODE] && !sync_serial_select) |=> (sda_oe == $past(ctrl_q[`TW_BIT_MDE]));
	endproperty
	a_mde: assert property (p_mde) else $error("data enable not following bit");

	property p_mco;
		@(posedge sys_clk) disable iff (!arst_n)
		(ctrl_q[`TW_BIT_MODE] && !sync_serial_select) |=> (scl_oe && scl_out == $past(ctrl_q[`TW_BIT_MCO]));
	endproperty
	a_mco: assert property (p_mco) else $error("clock pin not following master bit");

	property p_mdi;
		@(posedge sys_clk) disable iff (!arst_n)
		(ctrl_q[`TW_BIT_MODE] && !ctrl_q[`TW_BIT_MDE] && scl_rise && !(reg_req.wr && hit(reg_req, `TW_ADDR_CTRL)))
		|=> (ctrl_q[`TW_BIT_MDI] == $past(sda_s2_q));
	endproperty
	a_mdi: assert property (p_mdi) else $error("input bit not latched");

	property p_irst;
		@(posedge sys_clk) disable iff (!arst_n)
		(ctrl_q[`TW_BIT_IRST] && !ctrl_q[`TW_BIT_MODE]) |=> (st_q == TW_IDLE && !drv_low_q);
	endproperty
	a_irst: assert property (p_irst) else $error("slave not held in reset");

	property p_flag_set;
		@(posedge sys_clk) disable iff (!arst_n) flag_set |=> ctrl_q[`TW_BIT_FLAG];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set after byte");

	property p_flag_clr;
		@(posedge sys_clk) disable iff (!arst_n) (dat_acc && !flag_set) |=> (!ctrl_q[`TW_BIT_FLAG] && !byte_done_irq);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("access did not clear flag");

	property p_own;
		@(posedge sys_clk) disable iff (!arst_n)
		(reg_req.wr && hit(reg_req, `TW_ADDR_OWN)) |=> (own_q == $past(reg_req.wdata));
	endproperty
	a_own: assert property (p_own) else $error("own address not written");

	property p_spe;
		@(posedge sys_clk) disable iff (!arst_n) sync_serial_select |=> (!sda_oe && !scl_oe);
	endproperty
	a_spe: assert property (p_spe) else $error("pins driven while deselected");

	property p_match;
		@(posedge sys_clk) disable iff (!arst_n)
		(slave_on && !stop_c && !start_c && st_q == TW_ADDR && scl_fall && bit_q == 3'h0
			&& sh_q[7:1] != 7'h00 && sh_q[7:1] == own_q[6:0]) |=> (st_q == TW_AACK && drv_low_q);
	endproperty
	a_match: assert property (p_match) else $error("matching address not acknowledged");

	property p_nomatch;
		@(posedge sys_clk) disable iff (!arst_n) (st_q == TW_WAIT) |-> !drv_low_q;
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("drove bus without address match");

	property p_dir;
		@(posedge sys_clk) disable iff (!arst_n) (slave_on && st_q == TW_TX) |=> ctrl_q[`TW_BIT_DIR];
	endproperty
	a_dir: assert property (p_dir) else $error("direction not transmit");
endmodule : tw_core

//--- verification/tw_bus_master_model.sv
/*
 External two-wire bus master model that faces the hardware slave.
 Assumes open-drain wires with pull-ups, resolved in the bench from every party's pull-low.
*/
`timescale 1ns/1ps
module tw_bus_master_model (
	input  wire logic sda_line, // Resolved data wire
	output logic      sda_low,  // Pulls data wire low
	output logic      scl_low   // Pulls clock wire low
);
	////////////////////////////////////////////////////////////////////////////////
	// Idle with both wires released; the clock stands still between frames
	initial begin
		sda_low = 1'b0;
		scl_low = 1'b0;
	end

	// Holds the data wire at a level while the device owns the clock
	task automatic hold_data(input logic b);
		sda_low = ~b;
	endtask : hold_data

	// Start: data falls while clock is high
	task automatic start;
		sda_low = 1'b1;
		#40;
	endtask : start

	// Stop: data rises while clock is high
	task automatic stop;
		scl_low = 1'b1;
		#20 sda_low = 1'b1;
		#20 scl_low = 1'b0;
		#20 sda_low = 1'b0;
		#40;
	endtask : stop

	// One 80 ns bit; data moves mid low phase and is sampled mid high phase,
	// which leaves the slave's synchronisers time to answer
	task automatic bit_io(input logic b, output logic s);
		scl_low = 1'b1;
		#20 sda_low = ~b;
		#20 scl_low = 1'b0;
		#20 s = sda_line;
		#20;
	endtask : bit_io

	// Eight bits MSB first, then the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], s);
			rx[i] = s;
		end
		bit_io(ack_in, ack_out);
	endtask : xfer
endmodule : tw_bus_master_model

//--- verification/test_two_wire_sw_master_hw_slave.sv
/*
 Self-checking bench for the two-wire block: register port, software master pins, hardware slave.
 Assumes tw_defs.svh on the include path and the bus master model beside it.
*/
`timescale 1ns/1ps
`include "tw_defs.svh"
module test_two_wire_sw_master_hw_slave;
	import tw_pkg::*;
	logic           sys_clk, arst_n, sync_serial_select;
	logic           sda_out, sda_oe, scl_out, scl_oe, byte_done_irq, sda_low, scl_low;
	logic     [7:0] reg_rdata, v, c, d, rx, exp_own;
	logic           ack;
	logic     [7:0] exp_q[$];
	tw_reg_req_type reg_req;
	int             fails, checks;
	int             seed = 93;
	// Open-drain wires with pull-ups
	wire            sda_w = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	wire            scl_w = (scl_oe ? scl_out : 1'b1) & ~scl_low;

	////////////////////////////////////////////////////////////////////////////////
	tw_core i_tw_core (
		.sys_clk            (sys_clk),
		.arst_n             (arst_n),
		.reg_req            (reg_req),
		.reg_rdata          (reg_rdata),
		.sync_serial_select (sync_serial_select),
		.sda_in             (sda_w),
		.sda_out            (sda_out),
		.sda_oe             (sda_oe),
		.scl_in             (scl_w),
		.scl_out            (scl_out),
		.scl_oe             (scl_oe),
		.byte_done_irq      (byte_done_irq)
	);

	tw_bus_master_model i_tw_bus_master_model (
		.sda_line (sda_w),
		.sda_low  (sda_low),
		.scl_low  (scl_low)
	);

	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Step n edges, landing just after the last one so outputs are settled
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat);
		cyc(1);
		reg_req = '{a, 1'b1, 1'b0, dat};
		cyc(1);
		reg_req.wr = 1'b0;
	endtask : reg_wr

	// Read data is registered at the taking edge and holds until the next read
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] dat);
		cyc(1);
		reg_req = '{a, 1'b0, 1'b1, 8'h00};
		cyc(1);
		reg_req.rd = 1'b0;
		dat = reg_rdata;
	endtask : reg_rd

	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// Hang guard
	initial begin
		#200000;
		fails++;
		conclude;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		arst_n = 1'b0;
		sync_serial_select = 1'b0;
		reg_req = '0;
		repeat (12) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		// Reset values, an unmapped read, own address write-back
		reg_rd(`TW_ADDR_DATA, v);
		check("data reset", v, `TW_RST_DATA);
		reg_rd(`TW_ADDR_OWN, v);
		check("own reset", v, `TW_RST_OWN);
		reg_rd(`TW_ADDR_CTRL, v);
		check("ctrl reset", v, `TW_RST_CTRL);
		reg_rd(8'h3C, v);
		check("unmapped", v, 8'h00);
		exp_own = 8'h40 | (8'($random(seed)) & 8'h3F);
		reg_wr(`TW_ADDR_OWN, exp_own);
		reg_rd(`TW_ADDR_OWN, v);
		check("own", v, exp_own);
		// Software master: every combination of data, enable and clock bits
		for (int k = 0; k < 8; k++) begin
			c = {k[2:0], 5'b01011};
			reg_wr(`TW_ADDR_CTRL, c);
			cyc(3);
			check("scl pin", scl_w, c[5]);
			check("sda drive", sda_oe, c[6]);
			if (c[6]) check("sda pin", sda_w, c[7]);
		end
		reg_rd(`TW_ADDR_CTRL, v);
		check("ctrl ro bits", v & 8'hEF, c & 8'hEC);
		// Data pin captured on the clock rise while undriven
		for (int b = 0; b < 2; b++) begin
			reg_wr(`TW_ADDR_CTRL, 8'h08);
			i_tw_bus_master_model.hold_data(b[0]);
			reg_wr(`TW_ADDR_CTRL, 8'h28);
			cyc(8);
			reg_rd(`TW_ADDR_CTRL, v);
			check("data in", v[4], b[0]);
		end
		i_tw_bus_master_model.hold_data(1'b1);
		// Pins handed to the synchronous serial interface
		reg_wr(`TW_ADDR_CTRL, 8'hE8);
		sync_serial_select = 1'b1;
		cyc(3);
		check("oe select", {sda_oe, scl_oe}, 2'b00);
		sync_serial_select = 1'b0;
		// Hardware slave receive, then a foreign address, then interface held in reset
		reg_wr(`TW_ADDR_CTRL, 8'h00);
		cyc(3);
		d = 8'h01 | 8'($random(seed));
		i_tw_bus_master_model.start;
		i_tw_bus_master_model.xfer({exp_own[6:0], 1'b0}, 1'b1, rx, ack);
		check("addr ack", ack, 1'b0);
		i_tw_bus_master_model.xfer(d, 1'b1, rx, ack);
		check("data ack", ack, 1'b0);
		cyc(4);
		check("irq set", byte_done_irq, 1'b1);
		reg_rd(`TW_ADDR_CTRL, v);
		check("rx flag dir", v[1:0], 2'b01);
		i_tw_bus_master_model.stop;
		reg_rd(`TW_ADDR_DATA, v);
		check("rx byte", v, d);
		cyc(1);
		check("irq clear", byte_done_irq, 1'b0);
		for (int m = 0; m < 2; m++) begin
			reg_wr(`TW_ADDR_CTRL, m ? 8'h04 : 8'h00);
			cyc(3);
			i_tw_bus_master_model.start;
			i_tw_bus_master_model.xfer({exp_own[6:0] ^ (m ? 7'h00 : 7'h01), 1'b0}, 1'b1, rx, ack);
			check("no ack", ack, 1'b1);
			i_tw_bus_master_model.stop;
			check("no irq", byte_done_irq, 1'b0);
		end
		// Slave transmit: five writes into a four-word queue, then five reads with a stalling master
		reg_wr(`TW_ADDR_CTRL, 8'h00);
		for (int n = 0; n < 5; n++) begin
			d = 8'($random(seed));
			reg_wr(`TW_ADDR_DATA, d);
			if (n < `TW_FIFO_DEPTH) exp_q.push_back(d);
		end
		exp_q.push_back(8'hFF);
		i_tw_bus_master_model.start;
		i_tw_bus_master_model.xfer({exp_own[6:0], 1'b1}, 1'b1, rx, ack);
		check("rd addr ack", ack, 1'b0);
		for (int n = 0; n < 5; n++) begin
			i_tw_bus_master_model.xfer(8'hFF, n == 4, rx, ack);
			check("tx byte", rx, exp_q.pop_front());
			if (n == 0) begin
				cyc(4);
				check("tx irq", byte_done_irq, 1'b1);
				reg_rd(`TW_ADDR_CTRL, v);
				check("tx flag dir", v[1:0], 2'b11);
			end
			#2000;
		end
		i_tw_bus_master_model.stop;
		conclude;
	end
endmodule : test_two_wire_sw_master_hw_slave
